/* dmi_pkg.sv */
package dmi_pkg;

    // Packet store shape
    localparam int PKT_W     = 32;
    localparam int MEM_DEPTH = 16;

    // Data lines per transfer in each port configuration
    localparam logic [1:0] STEP_REDUCED = 2'h1;
    localparam logic [1:0] STEP_FULL    = 2'h2;

    // Input clock ratio expected from the tool
    localparam int MSG_CLK_RATIO = 2;

    // Reset values
    localparam logic FULL_MODE_RST = 1'b0;
    localparam logic ALT_D6_RST    = 1'b0;
    localparam logic MSG_OUT_START_END_N_IDLE     = 1'b1;
    localparam logic [1:0] MDO_IDLE = 2'h0;

    // Receive sequencer states
    typedef enum logic [2:0] {
        DMI_IDLE = 3'b001,
        DMI_DATA = 3'b010,
        DMI_PEND = 3'b100
    } dmi_state_e;

endpackage

/* dmi_msg_mem.sv */
`timescale 1ns/1ps
`default_nettype none

module dmi_msg_mem #(
    parameter int W     = 32,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    // Clock
    input  wire logic          clk,
    // Write side
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    // Read side
    input  wire logic [AW-1:0] rd_addr,
    output logic      [W-1:0]  rd_data
);

    logic [W-1:0] mem [DEPTH];

    // Write port
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read, one cycle latency
    always_ff @(posedge clk) begin
        rd_data <= mem[rd_addr];
    end

endmodule // dmi_msg_mem
`default_nettype wire

/* dmi_port.sv */
// Function
// - Low hard reset from the connector resets the whole controller.
// - Event-in acts by level, not edge, when set for breakpoints.
// - Low port reset clears port logic and reloads its configuration.
// - Start/end input going low marks the start of a message.
// - Start/end input low flags last transfer of packet and message end.
// - Reduced configuration carries data on input line zero only.
// - No third or fourth data input and no optional port line.
// - Alternate output bit six pin is off after reset until enabled.
// - Message output clock runs at the system clock frequency.
// - Reduced configuration has two data outputs and one data input.
`timescale 1ns/1ps
`default_nettype none

module dmi_port #(
    parameter int PKT_W = dmi_pkg::PKT_W,
    parameter int DEPTH = dmi_pkg::MEM_DEPTH,
    parameter int AW    = $clog2(DEPTH),
    parameter int CW    = $clog2(PKT_W) + 1
) (
    // Clock and reset
    input  wire logic          ref_clk,
    input  wire logic          sys_rst,
    // Debug connector inputs
    input  wire logic          system_hard_reset_n,
    input  wire logic          debug_port_reset_n,
    input  wire logic          event_in_n,
    input  wire logic          msg_in_clock,
    input  wire logic          msg_in_start_end_n,
    input  wire logic [1:0]    msg_in_data,
    // Debug connector outputs
    output logic               msg_out_clock,
    output logic      [1:0]    msg_out_data,
    output logic               msg_out_start_end_n,
    // Controller side control
    input  wire logic          brk_level_mode,
    input  wire logic          full_port_sel,
    input  wire logic          alt_d6_enable,
    output logic               mcu_reset,
    output logic               breakpoint_req,
    output logic               event_in_pulse,
    output logic               port_full_mode,
    output logic               alt_d6_pin_en,
    // Received packets
    output logic               msg_start,
    output logic               pkt_done,
    output logic               msg_done,
    output logic               pkt_overflow,
    output logic      [CW-1:0] pkt_bits,
    output logic      [AW-1:0] pkt_count,
    input  wire logic [AW-1:0] rd_addr,
    output logic [PKT_W-1:0]   rd_data
);
    import dmi_pkg::*;

    // Pin synchronisers: hard, port, event, clock, start/end, data[1:0]
    // only data lines zero and one are taken in; no port line
    logic [6:0] sync1;
    logic [6:0] sync2;
    always_ff @(posedge ref_clk) begin
        sync1 <= {system_hard_reset_n, debug_port_reset_n, event_in_n,
                  msg_in_clock, msg_in_start_end_n, msg_in_data};
        sync2 <= sync1;
    end

    logic       hard_s, port_s, evt_s, mclk_s, se_s;
    logic [1:0] din_s;
    assign {hard_s, port_s, evt_s, mclk_s, se_s, din_s} = sync2;

    // Edge history, fed from the second stage only
    logic mclk_q;
    logic evt_q;
    always_ff @(posedge ref_clk) begin
        mclk_q <= mclk_s;
        evt_q  <= evt_s;
    end

    // rising edge sample; each tool clock phase must span two edges
    logic mclk_rise;
    assign mclk_rise = mclk_s & ~mclk_q;

    // Unused port held low stays in reset here
    logic port_rst;
    assign port_rst = sys_rst | ~port_s | ~hard_s;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mcu_reset <= 1'b1;
        end else begin
            mcu_reset <= ~hard_s;
        end
    end

    // configuration reload
    // Config follows the select while in reset, frozen once the port runs
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            port_full_mode <= FULL_MODE_RST;
        end else if (port_rst) begin
            port_full_mode <= full_port_sel;
        end
    end

    // level sensitive breakpoint
    // Edge mode gives a single pulse on the falling edge instead
    always_ff @(posedge ref_clk) begin
        if (port_rst) begin
            breakpoint_req <= 1'b0;
            event_in_pulse <= 1'b0;
        end else begin
            breakpoint_req <= brk_level_mode & ~evt_s;
            event_in_pulse <= ~brk_level_mode & evt_q & ~evt_s;
        end
    end

    // alternate pin off at reset
    // Sticky once software turns it on; only a system reset clears it
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            alt_d6_pin_en <= ALT_D6_RST;
        end else if (alt_d6_enable) begin
            alt_d6_pin_en <= 1'b1;
        end
    end

    assign msg_out_clock = ref_clk;

    // two output data lines, held idle by this block
    always_ff @(posedge ref_clk) begin
        msg_out_data        <= MDO_IDLE;
        msg_out_start_end_n <= MSG_OUT_START_END_N_IDLE;
    end

    // Append one transfer to a packet word
    function automatic logic [PKT_W-1:0] put_bits(input logic [PKT_W-1:0] w,
                                                  input logic [CW-1:0] pos,
                                                  input logic [1:0] d,
                                                  input logic full);
        logic [PKT_W-1:0] r;
        r = w;
        r[pos[CW-2:0]] = d[0];
        if (full && (pos + CW'(1)) < CW'(PKT_W)) begin
            r[pos[CW-2:0] + 1'b1] = d[1];
        end
        return r;
    endfunction

    dmi_state_e       state;
    logic [PKT_W-1:0] word;
    logic [PKT_W-1:0] next_word;
    logic [CW-1:0]    next_bits;
    logic             next_ovf;
    logic [AW-1:0]    wr_ptr;
    logic             wr_en;

    // one bit per transfer when reduced, two when full
    always_comb begin
        logic [PKT_W-1:0] base_w;
        logic [CW-1:0]    base_c;
        logic [CW-1:0]    step;
        base_w    = (state == DMI_PEND) ? '0 : word;
        base_c    = (state == DMI_PEND) ? '0 : pkt_bits;
        step      = port_full_mode ? CW'(STEP_FULL) : CW'(STEP_REDUCED);
        next_ovf  = (base_c + step) > CW'(PKT_W);
        next_word = next_ovf ? base_w : put_bits(base_w, base_c, din_s, port_full_mode);
        next_bits = next_ovf ? base_c : base_c + step;
    end

    always_ff @(posedge ref_clk) begin
        if (port_rst) begin
            state    <= DMI_IDLE;
            word     <= '0;
            pkt_bits <= '0;
        end else if (mclk_rise) begin
            unique case (state)
                DMI_IDLE: begin
                    if (!se_s) begin
                        state    <= DMI_DATA;
                        word     <= '0;
                        pkt_bits <= '0;
                    end
                end
                DMI_DATA: begin
                    word     <= next_word;
                    pkt_bits <= next_bits;
                    if (!se_s) begin
                        state <= DMI_PEND;
                    end
                end
                DMI_PEND: begin
                    if (!se_s) begin
                        state <= DMI_IDLE;
                    end else begin
                        state    <= DMI_DATA;
                        word     <= next_word;
                        pkt_bits <= next_bits;
                    end
                end
            endcase
        end
    end

    // Event pulses and the packet store write
    assign wr_en = mclk_rise && state == DMI_DATA && !se_s;
    always_ff @(posedge ref_clk) begin
        if (port_rst) begin
            msg_start <= 1'b0;
            pkt_done  <= 1'b0;
            msg_done  <= 1'b0;
        end else begin
            msg_start <= mclk_rise && state == DMI_IDLE && !se_s;
            pkt_done  <= wr_en;
            msg_done  <= mclk_rise && state == DMI_PEND && !se_s;
        end
    end

    // Overflow is sticky until the port is reset; extra bits are dropped
    always_ff @(posedge ref_clk) begin
        if (port_rst) begin
            pkt_overflow <= 1'b0;
            wr_ptr       <= '0;
        end else begin
            if (mclk_rise && next_ovf && (state == DMI_DATA ||
                (state == DMI_PEND && se_s))) begin
                pkt_overflow <= 1'b1;
            end
            if (wr_en) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
        end
    end
    assign pkt_count = wr_ptr;

    dmi_msg_mem #(.W(PKT_W), .DEPTH(DEPTH), .AW(AW)) u_mem (
        .clk     (ref_clk),
        .wr_en   (wr_en),
        .wr_addr (wr_ptr),
        .wr_data (next_word),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    // Checks on the resets, breakpoint, alternate pin and the receive path
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (port_rst);

    sequence s_start_seen;
        mclk_rise && state == DMI_IDLE && !se_s;
    endsequence
    sequence s_last_xfer;
        mclk_rise && state == DMI_DATA && !se_s;
    endsequence
    sequence s_msg_close;
        mclk_rise && state == DMI_PEND && !se_s;
    endsequence

    a_hard_reset_out: assert property (disable iff (sys_rst)
        !hard_s |=> mcu_reset ##1 (mcu_reset || hard_s))
        else $error("hard reset not passed to controller");
    a_brk_level: assert property (
        (brk_level_mode && !evt_s) [*3] |=> breakpoint_req && !event_in_pulse)
        else $error("breakpoint not level driven");
    a_port_rst_idle: assert property (disable iff (sys_rst)
        port_rst |=> state == DMI_IDLE && pkt_bits == '0 && !pkt_done)
        else $error("port reset left receive state");
    a_cfg_reload: assert property (disable iff (sys_rst)
        port_rst && !sys_rst |=> port_full_mode == $past(full_port_sel))
        else $error("config not reloaded in port reset");
    a_msg_start: assert property (
        s_start_seen |=> msg_start && state == DMI_DATA && pkt_bits == '0)
        else $error("message start missed");
    a_pkt_end: assert property (
        s_last_xfer |=> pkt_done && state == DMI_PEND ##1 !pkt_done)
        else $error("packet end not flagged");
    a_msg_end: assert property (
        s_msg_close |=> msg_done && state == DMI_IDLE && !pkt_done)
        else $error("message end not flagged");
    a_reduced_step: assert property (
        mclk_rise && !port_full_mode && state == DMI_DATA && !next_ovf
        |=> pkt_bits == $past(pkt_bits) + 1'b1)
        else $error("reduced mode not one bit per transfer");
    a_rise_only: assert property (
        !mclk_rise |=> $stable(state) && $stable(pkt_bits))
        else $error("receive state moved without clock edge");
    a_alt_d6_cause: assert property (disable iff (sys_rst)
        $rose(alt_d6_pin_en) |-> $past(alt_d6_enable))
        else $error("alternate pin enabled without request");

endmodule // dmi_port
`default_nettype wire

/* dmi_tool_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Debug tool driving the message input link
module dmi_tool_model (
    // Clock used to pace the link
    input  wire logic       ref_clk,
    // Link pins
    output logic            msg_in_clock,
    output logic            msg_in_start_end_n,
    output logic [1:0]      msg_in_data
);
    // Released lines rest at the pull-up level, link clock parked low
    initial begin
        msg_in_clock       = 1'b0;
        msg_in_start_end_n = 1'b1;
        msg_in_data        = 2'h3;
    end

    // Lines set in low phase, held across the rise
    task automatic xfer(input logic se_n, input logic [1:0] d);
        @(posedge ref_clk) #2;
        msg_in_start_end_n = se_n;
        msg_in_data        = d;
        repeat (4) @(posedge ref_clk);
        #2 msg_in_clock = 1'b1;
        repeat (4) @(posedge ref_clk);
        #2 msg_in_clock = 1'b0;
        msg_in_start_end_n = 1'b1; // Released after the fall
        msg_in_data        = 2'h3;
    endtask

    // Low marker with no data: start, or end after a packet
    task automatic marker();
        xfer(1'b0, 2'h3);
    endtask

    // LSB first, low marker on the last transfer
    task automatic packet(input logic [31:0] w, input int nbits, input logic full);
        int step;
        int i;
        step = full ? 2 : 1;
        // Unused line one toggles against line zero so it cannot leak in
        for (i = 0; i < nbits; i += step) begin
            xfer((i + step >= nbits) ? 1'b0 : 1'b1, full ? w[i+:2] : {~w[i], w[i]});
        end
    endtask
endmodule // dmi_tool_model

`default_nettype wire

/* tb_dmi_port.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_dmi_port;
    import dmi_pkg::*;

    typedef struct { logic full; int nbits; logic [31:0] w; } dmi_row_s;

    logic ref_clk = 1'b0;
    logic sys_rst, system_hard_reset_n, debug_port_reset_n, event_in_n;
    logic msg_in_clock, msg_in_start_end_n, brk_level_mode, full_port_sel, alt_d6_enable;
    logic msg_out_clock, msg_out_start_end_n, mcu_reset, breakpoint_req, event_in_pulse;
    logic port_full_mode, alt_d6_pin_en, msg_start, pkt_done, msg_done, pkt_overflow;
    logic [1:0] msg_in_data, msg_out_data;
    logic [3:0] pkt_bits, pkt_count, rd_addr;
    logic [7:0] rd_data;
    int errors, check_count, n_start, n_pkt, n_done, n_evt;
    int s_start, s_pkt, s_done, s_evt;
    dmi_row_s rows [4] = '{'{0, 1, 1}, '{0, 8, 'ha5}, '{1, 2, 2}, '{1, 8, 'h3c}};

    // Clock, 50 ns period
    always #25 ref_clk = ~ref_clk;

    // Pulse counters on the falling edge, where outputs have settled
    always @(negedge ref_clk) begin
        if (msg_start === 1'b1) n_start++;
        if (pkt_done === 1'b1) n_pkt++;
        if (msg_done === 1'b1) n_done++;
        if (event_in_pulse === 1'b1) n_evt++;
    end

    // Narrow packet word keeps the overflow case brief
    dmi_port #(.PKT_W(8)) u_dut (.ref_clk, .sys_rst, .system_hard_reset_n,
        .debug_port_reset_n, .event_in_n, .msg_in_clock, .msg_in_start_end_n,
        .msg_in_data, .msg_out_clock, .msg_out_data, .msg_out_start_end_n,
        .brk_level_mode, .full_port_sel, .alt_d6_enable, .mcu_reset, .breakpoint_req,
        .event_in_pulse, .port_full_mode, .alt_d6_pin_en, .msg_start, .pkt_done,
        .msg_done, .pkt_overflow, .pkt_bits, .pkt_count, .rd_addr, .rd_data);

    dmi_tool_model u_tool (.ref_clk, .msg_in_clock, .msg_in_start_end_n, .msg_in_data);

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Bounded wait for the message end pulse
    task automatic wait_done();
        int k;
        for (k = 0; k < 40 && n_done == s_done; k++) tick(1);
        if (n_done == s_done) begin
            errors++;
            $display("[FAIL] msg_done expected 1 seen 0");
            end_sim();
        end
    endtask

    // Port reset pulse, loads the configuration
    task automatic port_reset(input logic full);
        full_port_sel = full;
        debug_port_reset_n = 1'b0;
        tick(3);
        debug_port_reset_n = 1'b1;
        tick(5);
        {s_start, s_pkt, s_done} = {n_start, n_pkt, n_done};
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] q);
        rd_addr = a;
        tick(2);
        q = rd_data;
    endtask

    initial begin
        logic [7:0] q;
        {sys_rst, system_hard_reset_n, debug_port_reset_n, event_in_n} = 4'hf;
        {brk_level_mode, full_port_sel, alt_d6_enable, rd_addr} = '0;
        tick(2);
        sys_rst = 1'b0;
        tick(4);
        chk("alt_d6_pin_en", 0, alt_d6_pin_en);
        chk("msg_out_data", 0, msg_out_data);
        chk("msg_out_start_end_n", 1, msg_out_start_end_n);
        chk("msg_out_clock", ref_clk, msg_out_clock);
        #25 chk("msg_out_clock", ref_clk, msg_out_clock);
        tick(1);
        alt_d6_enable = 1'b1;
        tick(2);
        alt_d6_enable = 1'b0;
        tick(2);
        chk("alt_d6_pin_en", 1, alt_d6_pin_en);
        // Ordinary messages; the select moves while running and must not apply
        foreach (rows[r]) begin
            port_reset(rows[r].full);
            chk("port_full_mode", rows[r].full, port_full_mode);
            full_port_sel = ~rows[r].full;
            u_tool.marker();
            u_tool.packet(rows[r].w, rows[r].nbits, rows[r].full);
            u_tool.marker();
            wait_done();
            tick(2);
            chk("msg_start", 1, n_start - s_start);
            chk("pkt_done", 1, n_pkt - s_pkt);
            chk("msg_done", 1, n_done - s_done);
            chk("pkt_bits", rows[r].nbits, pkt_bits);
            chk("pkt_count", 1, pkt_count);
            chk("pkt_overflow", 0, pkt_overflow);
            chk("port_full_mode", rows[r].full, port_full_mode);
            rd(0, q);
            chk("rd_data", rows[r].w, q);
        end
        // Two packets back to back, the second too long
        port_reset(1'b0);
        u_tool.marker();
        u_tool.packet('h5a, 8, 1'b0);
        u_tool.packet('h1c3, 9, 1'b0);
        u_tool.marker();
        wait_done();
        tick(2);
        chk("pkt_done", 2, n_pkt - s_pkt);
        chk("pkt_count", 2, pkt_count);
        chk("pkt_bits", 8, pkt_bits);
        chk("pkt_overflow", 1, pkt_overflow);
        rd(0, q);
        chk("rd_data", 'h5a, q);
        rd(1, q);
        chk("rd_data", 'hc3, q);
        // Hard reset clears the controller and the port
        system_hard_reset_n = 1'b0;
        tick(5);
        chk("mcu_reset", 1, mcu_reset);
        chk("pkt_count", 0, pkt_count);
        chk("pkt_overflow", 0, pkt_overflow);
        system_hard_reset_n = 1'b1;
        tick(5);
        chk("mcu_reset", 0, mcu_reset);
        // Traffic while the port is held in reset is ignored
        debug_port_reset_n = 1'b0;
        {s_start, s_pkt, s_done} = {n_start, n_pkt, n_done};
        u_tool.marker();
        u_tool.packet(1, 1, 1'b0);
        u_tool.marker();
        tick(10);
        chk("msg_start", 0, n_start - s_start);
        chk("msg_done", 0, n_done - s_done);
        chk("pkt_count", 0, pkt_count);
        chk("pkt_overflow", 0, pkt_overflow);
        debug_port_reset_n = 1'b1;
        // Event-in as level breakpoint, then as edge pulse
        brk_level_mode = 1'b1;
        event_in_n = 1'b0;
        tick(6);
        chk("breakpoint_req", 1, breakpoint_req);
        tick(10);
        chk("breakpoint_req", 1, breakpoint_req);
        event_in_n = 1'b1;
        tick(6);
        chk("breakpoint_req", 0, breakpoint_req);
        brk_level_mode = 1'b0;
        s_evt = n_evt;
        event_in_n = 1'b0;
        tick(10);
        chk("event_in_pulse", 1, n_evt - s_evt);
        chk("breakpoint_req", 0, breakpoint_req);
        event_in_n = 1'b1;
        // System reset in mid-run drops the sticky enable and the config
        sys_rst = 1'b1;
        tick(2);
        chk("alt_d6_pin_en", 0, alt_d6_pin_en);
        chk("mcu_reset", 1, mcu_reset);
        sys_rst = 1'b0;
        tick(2);
        chk("mcu_reset", 0, mcu_reset);
        chk("port_full_mode", FULL_MODE_RST, port_full_mode);
        end_sim();
    end
endmodule // tb_dmi_port

`default_nettype wire
